/* File: hw/sfm_pkg.sv */
// Functional notes
// - Write and read ports run on independent clocks.
// - Stopped port clocks lose no data or pointers.
// - Internal arbitration hides storage access conflicts.
// - Array is 512 by 512 bytes, sequential.
// - Line buffers give zero-latency first word.
// - Gated write edge stores byte, advances pointer.
// - Ungated write edge ignores byte, holds pointer.
// - Write gate has no minimum or maximum time.
// - Write mask low leaves location unchanged.
// - Write pointer advances whatever the mask level.
// - Write edge with clear high zeroes write pointer.
// - Write clear edge ignores gate and mask.
// - Gated read edge shifts next byte out.
// - Read gate decides whether read pointer advances.
// - Output bytes keep the written polarity.
// - Read edge with clear high zeroes read pointer.
// - Read clear edge ignores gate and output mask.
// - Output mask gates drivers, pointer still advances.
// - Slightly late read clear still returns previous field.
package sfm_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROWS = 512;
  localparam int unsigned COLS = 512;
  localparam int unsigned DEPTH = ROWS * COLS;
  localparam int unsigned ADDR_W = $clog2(DEPTH);
  localparam int unsigned LINE_DEPTH = 256;
  localparam int unsigned LINE_AW = $clog2(LINE_DEPTH);
  localparam int unsigned ENTRY_W = ADDR_W + 1 + DATA_W;

  // Entry layout inside the write line buffer.
  localparam int unsigned ENT_BYTE_LSB = 0;
  localparam int unsigned ENT_MASK_BIT = 8;
  localparam int unsigned ENT_ADDR_LSB = 9;

  // Bit positions of the synchronised port bundles.
  localparam int unsigned WR_SYNC_W = 11;
  localparam int unsigned WB_CLEAR = 10;
  localparam int unsigned WB_GATE = 9;
  localparam int unsigned WB_MASK = 8;
  localparam int unsigned RD_SYNC_W = 3;
  localparam int unsigned RB_CLEAR = 2;
  localparam int unsigned RB_GATE = 1;
  localparam int unsigned RB_MASK = 0;

  localparam logic [ADDR_W-1:0] PTR_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] PTR_ONE = 18'h00001;
  localparam logic [LINE_AW:0] CNT_RST = 9'h000;
  localparam logic [LINE_AW:0] CNT_ONE = 9'h001;
  localparam logic [LINE_AW:0] LINE_FULL = 9'h100;
  // Gated write clocks a byte waits before it may reach the array.
  localparam logic [LINE_AW:0] COMMIT_LAG = 9'h046;

  typedef struct packed {
    logic [ADDR_W-1:0] wr_ptr;
    logic [LINE_AW:0] flush_left;
    logic [ADDR_W-1:0] rd_ptr;
    logic fetch_pend;
    logic fetch_d;
    logic pre_valid;
    logic [DATA_W-1:0] prefetch;
    logic [DATA_W-1:0] dout;
    logic oe_b;
  } sfm_state_s;

  localparam sfm_state_s STATE_RST = '{
    wr_ptr: PTR_RST,
    flush_left: CNT_RST,
    rd_ptr: PTR_RST,
    fetch_pend: 1'b1,
    fetch_d: 1'b0,
    pre_valid: 1'b0,
    prefetch: 8'h00,
    dout: 8'h00,
    oe_b: 1'b1
  };

endpackage

/* File: hw/sfm_port_sync.sv */
`timescale 1ns/1ns
module sfm_port_sync #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  input wire logic [W-1:0] bits_in,
  output logic rise_out,
  output logic [W-1:0] bits_out
);
  import sfm_pkg::*;

  typedef struct packed {
    logic [W:0] s1;
    logic [W:0] s2;
    logic clk_d;
  } sfm_sync_s;

  sfm_sync_s r;
  sfm_sync_s nxt;

  // The port clock travels with its controls so that the bits seen at a
  // detected edge are the ones that stood at the pins around that edge.
  always_comb begin
    nxt = r;
    nxt.s1 = {link_clk_in, bits_in};
    nxt.s2 = r.s1;
    nxt.clk_d = r.s2[W];
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= nxt;
    end
  end

  // Only edges are acted on, so a clock parked high or low does nothing.
  assign rise_out = r.s2[W] & ~r.clk_d;
  assign bits_out = r.s2[W-1:0];

endmodule

/* File: hw/sfm_line_fifo.sv */
`timescale 1ns/1ns
module sfm_line_fifo (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [sfm_pkg::ENTRY_W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [sfm_pkg::ENTRY_W-1:0] out_data_out,
  output logic [sfm_pkg::LINE_AW:0] count_out
);
  import sfm_pkg::*;

  typedef struct packed {
    logic [LINE_AW-1:0] wp;
    logic [LINE_AW-1:0] rp;
    logic [LINE_AW:0] count;
  } sfm_fifo_s;

  sfm_fifo_s r;
  sfm_fifo_s nxt;
  logic [ENTRY_W-1:0] line_mem [LINE_DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (r.count != LINE_FULL);
  assign out_valid_out = (r.count != CNT_RST);
  assign out_data_out = line_mem[r.rp];
  assign count_out = r.count;

  always_comb begin
    nxt = r;
    push = in_valid_in && in_ready_out;
    pop = out_ready_in && out_valid_out;
    if (push) begin
      nxt.wp = r.wp + 8'h01;
    end
    if (pop) begin
      nxt.rp = r.rp + 8'h01;
    end
    if (push && !pop) begin
      nxt.count = r.count + CNT_ONE;
    end else if (pop && !push) begin
      nxt.count = r.count - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= nxt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (ce_in && push) begin
      line_mem[r.wp] <= in_data_in;
    end
  end

endmodule

/* File: hw/sfm_field_memory.sv */
`timescale 1ns/1ns
module sfm_field_memory (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic wr_clk_in,
  input wire logic wr_ptr_clear_in,
  input wire logic wr_advance_gate_in,
  input wire logic write_mask_gate_in,
  input wire logic [sfm_pkg::DATA_W-1:0] wr_byte_in,
  input wire logic rd_clk_in,
  input wire logic rd_ptr_clear_in,
  input wire logic rd_advance_gate_in,
  input wire logic rd_output_gate_in,
  output logic [sfm_pkg::DATA_W-1:0] rd_byte_out,
  output logic rd_byte_oe_b_out
);
  import sfm_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Plain binary step; the counters roll over from the top location.
  function automatic logic [ADDR_W-1:0] ptr_step(input logic [ADDR_W-1:0] p);
    ptr_step = p + PTR_ONE;
  endfunction

  // ---------------------------------------------------------------
  // Port synchronisers
  // ---------------------------------------------------------------

  logic wr_rise;
  logic [WR_SYNC_W-1:0] wr_bits;
  logic rd_rise;
  logic [RD_SYNC_W-1:0] rd_bits;

  // Each port has its own sampler, so neither clock depends on the other.
  sfm_port_sync #(
    .W(WR_SYNC_W)
  ) u_wr_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .link_clk_in(wr_clk_in),
    .bits_in({wr_ptr_clear_in, wr_advance_gate_in, write_mask_gate_in, wr_byte_in}),
    .rise_out(wr_rise),
    .bits_out(wr_bits)
  );

  sfm_port_sync #(
    .W(RD_SYNC_W)
  ) u_rd_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .link_clk_in(rd_clk_in),
    .bits_in({rd_ptr_clear_in, rd_advance_gate_in, rd_output_gate_in}),
    .rise_out(rd_rise),
    .bits_out(rd_bits)
  );

  logic wr_clr;
  logic wr_gate;
  logic wr_mask;
  logic [DATA_W-1:0] wr_byte;
  logic rd_clr;
  logic rd_gate;
  logic rd_mask;

  assign wr_clr = wr_bits[WB_CLEAR];
  assign wr_gate = wr_bits[WB_GATE];
  assign wr_mask = wr_bits[WB_MASK];
  assign wr_byte = wr_bits[DATA_W-1:0];
  assign rd_clr = rd_bits[RB_CLEAR];
  assign rd_gate = rd_bits[RB_GATE];
  assign rd_mask = rd_bits[RB_MASK];

  // ---------------------------------------------------------------
  // Write line buffer
  // ---------------------------------------------------------------

  sfm_state_s r;
  sfm_state_s nxt;
  logic push;
  logic pop;
  logic fetch;
  logic mem_we;
  logic commit_due;
  logic fifo_ready;
  logic fifo_valid;
  logic [ENTRY_W-1:0] fifo_data;
  logic [LINE_AW:0] fifo_count;
  logic [ADDR_W-1:0] ent_addr;
  logic ent_mask;
  logic [DATA_W-1:0] ent_byte;

  // Bytes wait here until enough newer bytes have followed them, which is
  // what lets a slightly late read clear still see the previous field.
  sfm_line_fifo u_line (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_data_in({r.wr_ptr, wr_mask, wr_byte}),
    .in_ready_out(fifo_ready),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data),
    .count_out(fifo_count)
  );

  assign ent_addr = fifo_data[ENT_ADDR_LSB +: ADDR_W];
  assign ent_mask = fifo_data[ENT_MASK_BIT];
  assign ent_byte = fifo_data[ENT_BYTE_LSB +: DATA_W];

  // ---------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------

  logic [DATA_W-1:0] field_mem [DEPTH];
  logic [DATA_W-1:0] mem_q;

  // One access per cycle; the arbiter below never asks for two.
  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      if (mem_we) begin
        field_mem[ent_addr] <= ent_byte;
      end
      if (fetch) begin
        mem_q <= field_mem[r.rd_ptr];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control
  // ---------------------------------------------------------------

  always_comb begin
    nxt = r;
    push = 1'b0;

    // Read prefetch wins the array; a commit only waits one cycle.
    fetch = r.fetch_pend;
    nxt.fetch_pend = 1'b0;
    nxt.fetch_d = fetch;
    if (r.fetch_d) begin
      nxt.prefetch = mem_q;
      nxt.pre_valid = 1'b1;
    end

    commit_due = fifo_valid && ((fifo_count > COMMIT_LAG) || (r.flush_left != CNT_RST));
    pop = commit_due && !fetch;
    mem_we = pop && ent_mask;
    if (pop && (r.flush_left != CNT_RST)) begin
      nxt.flush_left = r.flush_left - CNT_ONE;
    end

    if (wr_rise) begin
      if (wr_clr) begin
        // Everything still buffered belongs to the closing field.
        nxt.wr_ptr = PTR_RST;
        nxt.flush_left = fifo_count - {{LINE_AW{1'b0}}, pop};
      end else if (wr_gate) begin
        // Only the sampled level matters, so any gate duration works.
        push = fifo_ready;
        nxt.wr_ptr = ptr_step(r.wr_ptr);
      end
    end

    if (rd_rise) begin
      if (rd_clr) begin
        nxt.rd_ptr = PTR_RST;
        nxt.fetch_pend = 1'b1;
        nxt.pre_valid = 1'b0;
      end else begin
        nxt.oe_b = ~rd_mask;
        if (rd_gate) begin
          nxt.dout = r.prefetch;
          nxt.rd_ptr = ptr_step(r.rd_ptr);
          nxt.fetch_pend = 1'b1;
          nxt.pre_valid = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      r <= STATE_RST;
    end else if (ce_in) begin
      r <= nxt;
    end
  end

  assign rd_byte_out = r.dout;
  assign rd_byte_oe_b_out = r.oe_b;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence wr_clear_s;
    ce_in && wr_rise && wr_clr;
  endsequence

  sequence wr_gated_s;
    ce_in && wr_rise && !wr_clr && wr_gate;
  endsequence

  sequence rd_clear_s;
    ce_in && rd_rise && rd_clr;
  endsequence

  sequence rd_gated_s;
    ce_in && rd_rise && !rd_clr && rd_gate;
  endsequence

  sequence refill_s;
    ##[1:3] r.pre_valid;
  endsequence

  wr_clear_zero_a: assert property (wr_clear_s |=> (r.wr_ptr == PTR_RST) && !$past(push))
    else $error("write clear did not zero the write pointer");

  wr_gated_step_a: assert property (wr_gated_s |=> r.wr_ptr == ptr_step($past(r.wr_ptr)))
    else $error("gated write edge did not step the write pointer");

  wr_hold_ptr_a: assert property (ce_in && wr_rise && !wr_clr && !wr_gate |=> $stable(r.wr_ptr))
    else $error("ungated write edge moved the write pointer");

  wr_mask_block_a: assert property (pop && !ent_mask |-> !mem_we)
    else $error("masked byte reached the array");

  commit_lag_a: assert property (pop |-> (fifo_count > COMMIT_LAG) || (r.flush_left != CNT_RST))
    else $error("byte committed before its lag ran out");

  rd_clear_zero_a: assert property (rd_clear_s |=> (r.rd_ptr == PTR_RST) && $stable(r.dout))
    else $error("read clear did not zero the read pointer");

  rd_clear_oe_a: assert property (rd_clear_s |=> $stable(r.oe_b))
    else $error("read clear changed the output enable");

  rd_shift_a: assert property (rd_gated_s |=> (r.dout == $past(r.prefetch))
    && (r.rd_ptr == ptr_step($past(r.rd_ptr))))
    else $error("gated read edge did not shift the prefetched byte");

  rd_mask_oe_a: assert property (ce_in && rd_rise && !rd_clr |=> r.oe_b == !$past(rd_mask))
    else $error("output enable does not follow the sampled mask");

  prefetch_refill_a: assert property (rd_gated_s or rd_clear_s |-> refill_s)
    else $error("prefetch not refilled within three cycles");

  // ---------------------------------------------------------------
  // Idle and arbitration checks
  // ---------------------------------------------------------------

  // A port clock may be parked at either level for as long as the
  // controller likes, so no pointer or read output may move without an edge.
  sequence wr_idle_s;
    !(ce_in && wr_rise);
  endsequence

  sequence rd_idle_s;
    !(ce_in && rd_rise);
  endsequence

  sequence wr_ungated_s;
    ce_in && wr_rise && !wr_clr && !wr_gate;
  endsequence

  sequence rd_ungated_s;
    ce_in && rd_rise && !rd_clr && !rd_gate;
  endsequence

  wr_idle_ptr_a: assert property (wr_idle_s
    |=> $stable(r.wr_ptr))
    else $error("write pointer moved with no write edge");

  rd_idle_hold_a: assert property (rd_idle_s
    |=> $stable(r.rd_ptr) && $stable(r.dout))
    else $error("read side moved with no read edge");

  rd_idle_oe_a: assert property (rd_idle_s
    |=> $stable(r.oe_b))
    else $error("output enable moved with no read edge");

  wr_ungated_drop_a: assert property (wr_ungated_s
    |-> !push)
    else $error("ungated write edge stored a byte");

  rd_ungated_hold_a: assert property (rd_ungated_s
    |=> $stable(r.rd_ptr) && $stable(r.dout))
    else $error("ungated read edge moved the read side");

  // The commit lag keeps the buffer far from full at any legal write rate.
  wr_gated_room_a: assert property (wr_gated_s
    |-> fifo_ready && push)
    else $error("gated write found the line buffer full");

  one_access_a: assert property (fetch
    |-> !pop && !mem_we)
    else $error("prefetch and commit shared the array");

  array_write_a: assert property (mem_we
    |-> pop && ent_mask)
    else $error("array written without an unmasked commit");

  // A commit loses the array to a prefetch for one cycle at the most.
  commit_wait_a: assert property (ce_in && commit_due && !pop
    |=> !ce_in || pop || !commit_due)
    else $error("commit held off for more than one cycle");

  flush_count_a: assert property ((r.flush_left != CNT_RST)
    |-> fifo_valid && (r.flush_left <= fifo_count))
    else $error("flush count exceeds buffered bytes");

  rd_out_change_a: assert property ($changed(r.dout)
    |-> $past(ce_in && rd_rise && !rd_clr && rd_gate))
    else $error("output byte changed without a gated read edge");

  oe_change_a: assert property ($changed(r.oe_b)
    |-> $past(ce_in && rd_rise && !rd_clr))
    else $error("output enable changed outside a read edge");

  wr_ptr_change_a: assert property ($changed(r.wr_ptr)
    |-> $past(ce_in && wr_rise && (wr_clr || wr_gate)))
    else $error("write pointer changed without a clear or gated edge");

  rd_gated_fetch_a: assert property (rd_gated_s
    |=> fetch)
    else $error("gated read edge did not start a prefetch");

  rd_clear_fetch_a: assert property (rd_clear_s
    |=> fetch)
    else $error("read clear did not start a prefetch");

endmodule

/* File: test/sfm_ctrl_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Video controller model
// ----------------------------------------
module sfm_ctrl_model (
  output logic wr_clk_out,
  output logic wr_ptr_clear_out,
  output logic wr_advance_gate_out,
  output logic write_mask_gate_out,
  output logic [sfm_pkg::DATA_W-1:0] wr_byte_out,
  output logic rd_clk_out,
  output logic rd_ptr_clear_out,
  output logic rd_advance_gate_out,
  output logic rd_output_gate_out,
  output logic rd_tick_out
);
  import sfm_pkg::*;
  localparam int HALF = 40;
  initial begin
    wr_clk_out = 1'b0;
    wr_ptr_clear_out = 1'b0;
    wr_advance_gate_out = 1'b0;
    write_mask_gate_out = 1'b0;
    wr_byte_out = 8'h00;
    rd_clk_out = 1'b0;
    rd_ptr_clear_out = 1'b0;
    rd_advance_gate_out = 1'b0;
    rd_output_gate_out = 1'b0;
    rd_tick_out = 1'b0;
  end
  // Controls change half a period before the rising edge, so they are stable
  // while the block samples them. Port clocks stand still between calls.
  task automatic wr_cycle(input logic clr, input logic gate, input logic mask,
    input logic [DATA_W-1:0] data);
    wr_ptr_clear_out = clr;
    wr_advance_gate_out = gate;
    write_mask_gate_out = mask;
    // A byte sent with the gate low is not left standing on the lines.
    wr_byte_out = gate ? data : ~wr_byte_out;
    #HALF wr_clk_out = 1'b1;
    #HALF wr_clk_out = 1'b0;
  endtask
  // The tick marks the end of a checked read cycle, when the answer stands.
  task automatic rd_cycle(input logic clr, input logic gate, input logic oe,
    input logic chk);
    rd_ptr_clear_out = clr;
    rd_advance_gate_out = gate;
    rd_output_gate_out = oe;
    #HALF rd_clk_out = 1'b1;
    #HALF rd_clk_out = 1'b0;
    if (chk) rd_tick_out = ~rd_tick_out;
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import sfm_pkg::*;
  localparam int N = 100;
  localparam int TMO = 20000;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wclk, wclr, wgate, wmask, rclk, rclr, rgate, roe, rd_tick;
  logic [DATA_W-1:0] wbyte, rd_byte_out;
  logic rd_byte_oe_b_out;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [DATA_W-1:0] exp_mem [int];
  logic [DATA_W:0] exp_q [$];
  logic [DATA_W:0] exp_e;
  logic [ADDR_W-1:0] wp = '0;
  logic [ADDR_W-1:0] rp = '0;
  logic [DATA_W-1:0] edout = 8'h00;
  logic eoeb = 1'b1;

  always #5 ref_clk_in = ~ref_clk_in;

  sfm_ctrl_model i_ctrl (.wr_clk_out(wclk), .wr_ptr_clear_out(wclr),
    .wr_advance_gate_out(wgate), .write_mask_gate_out(wmask), .wr_byte_out(wbyte),
    .rd_clk_out(rclk), .rd_ptr_clear_out(rclr), .rd_advance_gate_out(rgate),
    .rd_output_gate_out(roe), .rd_tick_out(rd_tick));

  sfm_field_memory i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .wr_clk_in(wclk), .wr_ptr_clear_in(wclr), .wr_advance_gate_in(wgate),
    .write_mask_gate_in(wmask), .wr_byte_in(wbyte), .rd_clk_in(rclk),
    .rd_ptr_clear_in(rclr), .rd_advance_gate_in(rgate), .rd_output_gate_in(roe),
    .rd_byte_out(rd_byte_out), .rd_byte_oe_b_out(rd_byte_oe_b_out));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [DATA_W:0] exp,
    input logic [DATA_W:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      n_errors++;
      finish_test();
    end
  end

  // Each checked read cycle yields one result: output enable and byte.
  always @(rd_tick) begin
    if (rst_b_in === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value rd_queue expected entry seen none");
      end else begin
        exp_e = exp_q.pop_front();
        check("rd_byte", exp_e, {rd_byte_oe_b_out, rd_byte_out});
      end
    end
  end

  // ----------------------------------------
  // Port cycles with reference model
  // ----------------------------------------
  task automatic wcyc(input logic c, input logic g, input logic m,
    input logic [DATA_W-1:0] b);
    if (c) begin
      wp = '0;
    end else if (g) begin
      if (m) exp_mem[int'(wp)] = b;
      wp = wp + PTR_ONE;
    end
    i_ctrl.wr_cycle(c, g, m, b);
  endtask

  task automatic rcyc(input logic c, input logic g, input logic o, input logic chk);
    if (c) begin
      rp = '0;
    end else begin
      eoeb = ~o;
      if (g) begin
        edout = exp_mem[int'(rp)];
        rp = rp + PTR_ONE;
      end
    end
    if (chk) exp_q.push_back({eoeb, edout});
    i_ctrl.rd_cycle(c, g, o, chk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(45393));
    repeat (8) @(posedge ref_clk_in);
    #1;
    check("reset_out", {1'b1, 8'h00}, {rd_byte_oe_b_out, rd_byte_out});
    rst_b_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    fork
      repeat (80) wcyc(1'b0, 1'b0, 1'b0, 8'h00);
      repeat (80) rcyc(1'b0, 1'b0, 1'b0, 1'b0);
    join
    wcyc(1'b1, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < N; i++) wcyc(1'b0, 1'b1, 1'b1, 8'($urandom));
    wcyc(1'b1, 1'b1, 1'b1, 8'hA5);
    for (int i = 0; i < N; i++) begin
      // Write clock stopped low for a long pause mid-field.
      if (i == 40) #3000;
      if (i % 7 == 3) wcyc(1'b0, 1'b0, 1'b1, 8'($urandom));
      wcyc(1'b0, 1'b1, 1'($urandom), 8'($urandom));
    end
    wcyc(1'b1, 1'b0, 1'b0, 8'h00);
    repeat (600) wcyc(1'b0, 1'b1, 1'b0, 8'($urandom));
    rcyc(1'b1, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 120; i++) rcyc(1'b0, (i % 5) != 4, 1'($urandom), 1'b1);
    i_ctrl.wr_cycle(1'b1, 1'b0, 1'b0, 8'h00);
    repeat (50) i_ctrl.wr_cycle(1'b0, 1'b1, 1'b1, 8'($urandom));
    rcyc(1'b1, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 85; i++) rcyc(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge ref_clk_in);
    finish_test();
  end
endmodule
